// File: src/ccr_regs.svh
// Purpose: Offsets, field positions and reset values of the control register bank
// Assumes: Byte-wide registers, one per aligned 32-bit Avalon word
// Notes: Byte address is four times the register index
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
`define CCR_IDX_PORT_CFG 8'h00
`define CCR_IDX_STOP_REC 8'h0B
`define CCR_IDX_STOP_REC2 8'h0D
`define CCR_IDX_WDOG_MODE 8'h0F
`define CCR_IDX_FLAGS 8'hFC
`define CCR_IDX_REG_PTR 8'hFD
`define CCR_IDX_GP_BYTE 8'hFE
`define CCR_IDX_SP_LOW 8'hFF
`define CCR_IDX_STOP_EVT 8'hF0
`define CCR_BANK_F 4'hF
`define CCR_RST_PORT_CFG 8'hFE
`define CCR_RST_STOP_REC 8'h20
`define CCR_RST_STOP_REC2 8'h00
`define CCR_RST_WDOG_MODE 8'h0D
`define CCR_RST_ZERO 8'h00
`define CCR_PCFG_OSC 7
`define CCR_PCFG_P3 6
`define CCR_PCFG_P2 5
`define CCR_PCFG_P0_DRV 3
`define CCR_PCFG_P0_PP 2
`define CCR_PCFG_CMP 0
`define CCR_STOP_FLAG 7
`endif

// File: src/ccr_pkg.sv
// Purpose: Types shared by the control register bank
// Assumes: Nothing beyond the register header
// Notes: Flag layout carry high to user flag one low
package ccr_pkg;
    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic overflow;
        logic dec_adjust;
        logic half_carry;
        logic user_flag_two;
        logic user_flag_one;
    } ccr_flags_t;
    typedef struct packed {
        logic osc_standard;
        logic port3_standard;
        logic port2_standard;
        logic port0_standard;
        logic port0_push_pull;
        logic cmp_to_port3;
    } ccr_port_ctl_t;
    typedef enum logic [1:0] {
        CCR_IDLE = 2'b00,
        CCR_RESP = 2'b01
    } ccr_bus_state_t;
endpackage

// File: src/ccr_flag_reg.sv
// Purpose: Status flag register with core updates and software override
// Assumes: Core update and software write arrive synchronous to clk_sys
// Notes: Contents survive reset; user flags are software owned
`timescale 1ns/10ps
module ccr_flag_reg
    import ccr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic core_upd,
    input wire logic [5:0] core_flags,
    input wire logic sw_wr,
    input wire logic [7:0] sw_data,
    output ccr_flags_t flags
);
    typedef struct packed {
        ccr_flags_t f;
        logic sw_seen;
    } ccr_flag_st_t;
    ccr_flag_st_t st;
    ccr_flag_st_t next_st;

    always_comb
    begin
        next_st = st;
        // Checking aid: high once software has given the flags a known value
        next_st.sw_seen = st.sw_seen | sw_wr;
        if (sw_wr)
        begin
            next_st.f = ccr_flags_t'(sw_data);
        end
        else if (core_upd)
        begin
            next_st.f[7:2] = core_flags;
        end
    end

    // No reset term: flag contents, user flags included, pass reset untouched
    always_ff @(posedge clk_sys)
    begin
        st <= next_st;
    end

    assign flags = st.f;

    property p_sw_over_core;
        @(posedge clk_sys) disable iff (sys_rst) sw_wr |=> (flags == $past(sw_data));
    endproperty
    a_sw_over_core: assert property (p_sw_over_core) else $error("flag write lost");
    property p_user_kept;
        @(posedge clk_sys) (st.sw_seen && !sw_wr) |=> (flags[1:0] == $past(flags[1:0]));
    endproperty
    a_user_kept: assert property (p_user_kept) else $error("user flags changed");
endmodule // ccr_flag_reg

// File: src/ccr_ctrl_regs.sv
// Purpose: Processor control and port configuration registers on Avalon-MM
// Assumes: Byte data in bits 7:0, word address is the register index
// Notes: Bank F locations decode only while the pointer selects bank F
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "ccr_regs.svh"
module ccr_ctrl_regs
    import ccr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic core_flag_upd,
    input wire logic [5:0] core_flags,
    input wire logic stop_recovery,
    input wire logic [7:0] port3_data,
    input wire logic [1:0] cmp_result,
    output ccr_flags_t status_flags,
    output logic [3:0] working_group,
    output logic [3:0] bank_select,
    output logic [7:0] stack_pointer_low_bits,
    output ccr_port_ctl_t port_ctl,
    output logic [7:0] stop_rec_cfg,
    output logic [7:0] stop_rec_cfg_two,
    output logic [7:0] watchdog_cfg,
    output logic port3_pin4,
    output logic port3_pin7
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        ccr_bus_state_t bus;
        logic [7:0] rdata;
        logic [7:0] register_pointer;
        logic [7:0] general_purpose_byte;
        logic [7:0] stack_pointer_low;
        logic [7:0] port_configuration;
        logic [6:0] stop_recovery_control;
        logic stop_flag;
        logic [7:0] stop_recovery_control_two;
        logic [7:0] watchdog_mode;
        logic pin4;
        logic pin7;
    } ccr_state_t;

    ccr_state_t st;
    ccr_state_t next_st;
    logic flag_wr;
    ccr_flags_t flags_q;

    // Bank F locations are visible only while the bank select field is F
    function automatic logic bank_f_hit(input logic [7:0] idx, input logic [7:0] rp,
                                        input logic [7:0] want);
        return (rp[3:0] == `CCR_BANK_F) && (idx == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        flag_wr = 1'b0;
        if (stop_recovery)
        begin
            next_st.stop_flag = 1'b1;
        end
        case (st.bus)
            CCR_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    next_st.bus = CCR_RESP;
                end
                if (avs_read)
                begin
                    next_st.rdata = `CCR_RST_ZERO;
                    case (avs_address)
                        `CCR_IDX_FLAGS: next_st.rdata = flags_q;
                        `CCR_IDX_REG_PTR: next_st.rdata = st.register_pointer;
                        `CCR_IDX_GP_BYTE: next_st.rdata = st.general_purpose_byte;
                        `CCR_IDX_SP_LOW: next_st.rdata = st.stack_pointer_low;
                        default: next_st.rdata = `CCR_RST_ZERO;
                    endcase
                    if (bank_f_hit(avs_address, st.register_pointer, `CCR_IDX_STOP_REC))
                    begin
                        next_st.rdata = {st.stop_flag, 7'h00};
                    end
                end
                if (avs_write)
                begin
                    case (avs_address)
                        `CCR_IDX_FLAGS: flag_wr = 1'b1;
                        `CCR_IDX_REG_PTR: next_st.register_pointer = avs_writedata[7:0];
                        `CCR_IDX_GP_BYTE: next_st.general_purpose_byte = avs_writedata[7:0];
                        `CCR_IDX_SP_LOW: next_st.stack_pointer_low = avs_writedata[7:0];
                        default: next_st.bus = CCR_RESP;
                    endcase
                    if (bank_f_hit(avs_address, st.register_pointer, `CCR_IDX_PORT_CFG))
                    begin
                        next_st.port_configuration = avs_writedata[7:0];
                    end
                    if (bank_f_hit(avs_address, st.register_pointer, `CCR_IDX_STOP_REC))
                    begin
                        next_st.stop_recovery_control = avs_writedata[6:0];
                    end
                    if (bank_f_hit(avs_address, st.register_pointer, `CCR_IDX_STOP_REC2))
                    begin
                        next_st.stop_recovery_control_two = avs_writedata[7:0];
                    end
                    if (bank_f_hit(avs_address, st.register_pointer, `CCR_IDX_WDOG_MODE))
                    begin
                        next_st.watchdog_mode = avs_writedata[7:0];
                    end
                end
            end
            CCR_RESP:
            begin
                next_st.bus = CCR_IDLE;
            end
            default:
            begin
                next_st.bus = CCR_IDLE;
            end
        endcase
        // Comparator routing onto port 3 pins 4 and 7
        if (st.port_configuration[`CCR_PCFG_CMP])
        begin
            next_st.pin4 = cmp_result[0];
            next_st.pin7 = cmp_result[1];
        end
        else
        begin
            next_st.pin4 = port3_data[4];
            next_st.pin7 = port3_data[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only sys_rst restores bank F; stop recovery only sets the stop flag
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st.bus <= CCR_IDLE;
            st.rdata <= `CCR_RST_ZERO;
            st.register_pointer <= `CCR_RST_ZERO;
            st.general_purpose_byte <= `CCR_RST_ZERO;
            st.stack_pointer_low <= `CCR_RST_ZERO;
            st.port_configuration <= `CCR_RST_PORT_CFG;
            st.stop_recovery_control <= 7'(`CCR_RST_STOP_REC);
            st.stop_flag <= 1'b0;
            st.stop_recovery_control_two <= `CCR_RST_STOP_REC2;
            st.watchdog_mode <= `CCR_RST_WDOG_MODE;
            st.pin4 <= 1'b0;
            st.pin7 <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ccr_flag_reg u_flags (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .core_upd(core_flag_upd),
        .core_flags(core_flags),
        .sw_wr(flag_wr),
        .sw_data(avs_writedata[7:0]),
        .flags(flags_q)
    );

    // Read data valid in the response cycle; waitrequest low there
    assign avs_waitrequest = (st.bus != CCR_RESP);
    assign avs_readdata = {24'h000000, st.rdata};
    assign status_flags = flags_q;
    assign working_group = st.register_pointer[7:4];
    assign bank_select = st.register_pointer[3:0];
    assign stack_pointer_low_bits = st.stack_pointer_low;
    // Port 1 has no control here at all
    assign port_ctl.osc_standard = st.port_configuration[`CCR_PCFG_OSC];
    assign port_ctl.port3_standard = st.port_configuration[`CCR_PCFG_P3];
    assign port_ctl.port2_standard = st.port_configuration[`CCR_PCFG_P2];
    assign port_ctl.port0_standard = st.port_configuration[`CCR_PCFG_P0_DRV];
    assign port_ctl.port0_push_pull = st.port_configuration[`CCR_PCFG_P0_PP];
    assign port_ctl.cmp_to_port3 = st.port_configuration[`CCR_PCFG_CMP];
    assign stop_rec_cfg = {st.stop_flag, st.stop_recovery_control};
    assign stop_rec_cfg_two = st.stop_recovery_control_two;
    assign watchdog_cfg = st.watchdog_mode;
    assign port3_pin4 = st.pin4;
    assign port3_pin7 = st.pin7;

    ////////////////////////////////////////////////////////////////////////////
    // Requests taken at this edge, for the checks below
    logic wr_taken;
    logic rd_taken;
    assign wr_taken = (st.bus == CCR_IDLE) && avs_write;
    assign rd_taken = (st.bus == CCR_IDLE) && avs_read;

    property p_stop_sets_flag;
        @(posedge clk_sys) disable iff (sys_rst) stop_recovery |=> stop_rec_cfg[7];
    endproperty
    a_stop_sets_flag: assert property (p_stop_sets_flag) else $error("stop flag not set");
    property p_flag_sticky;
        @(posedge clk_sys) disable iff (sys_rst) stop_rec_cfg[7] |=> stop_rec_cfg[7];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("stop flag dropped");
    property p_bank_keep;
        @(posedge clk_sys) disable iff (sys_rst)
            (stop_recovery && !avs_write) |=> $stable(st.port_configuration) && $stable(watchdog_cfg);
    endproperty
    a_bank_keep: assert property (p_bank_keep) else $error("bank F lost on recovery");
    // Bank 0 writes and reserved bank F places leave bank F untouched
    property p_resv_write;
        @(posedge clk_sys) disable iff (sys_rst)
            (wr_taken && !stop_recovery
                && avs_address != `CCR_IDX_PORT_CFG && avs_address != `CCR_IDX_STOP_REC
                && avs_address != `CCR_IDX_STOP_REC2 && avs_address != `CCR_IDX_WDOG_MODE)
            |=> $stable(port_ctl) && $stable(stop_rec_cfg) && $stable(stop_rec_cfg_two)
                && $stable(watchdog_cfg);
    endproperty
    a_resv_write: assert property (p_resv_write) else $error("reserved write landed");
    property p_pcfg_gate;
        @(posedge clk_sys) disable iff (sys_rst)
            (st.bus == CCR_IDLE && avs_write && bank_select != `CCR_BANK_F)
            |=> $stable(port_ctl) && $stable(watchdog_cfg);
    endproperty
    a_pcfg_gate: assert property (p_pcfg_gate) else $error("bank F written off bank");
    property p_rp_write;
        @(posedge clk_sys) disable iff (sys_rst)
            (st.bus == CCR_IDLE && avs_write && avs_address == `CCR_IDX_REG_PTR)
            |=> ##1 (working_group == $past(avs_writedata[7:4], 2));
    endproperty
    a_rp_write: assert property (p_rp_write) else $error("pointer write wrong");
    property p_cmp_route;
        @(posedge clk_sys) disable iff (sys_rst)
            port_ctl.cmp_to_port3 |=> (port3_pin4 == $past(cmp_result[0]));
    endproperty
    a_cmp_route: assert property (p_cmp_route) else $error("comparator not routed");
    property p_norm_route;
        @(posedge clk_sys) disable iff (sys_rst)
            !port_ctl.cmp_to_port3 |=> (port3_pin7 == $past(port3_data[7]));
    endproperty
    a_norm_route: assert property (p_norm_route) else $error("port data not routed");
    property p_one_wait;
        @(posedge clk_sys) disable iff (sys_rst)
            (st.bus == CCR_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer timing");

    // Port configuration fields follow the written byte
    property p_pcfg_write;
        @(posedge clk_sys) disable iff (sys_rst)
            (wr_taken && bank_select == `CCR_BANK_F && avs_address == `CCR_IDX_PORT_CFG)
            |=> (port_ctl.osc_standard == $past(avs_writedata[`CCR_PCFG_OSC]))
                && (port_ctl.port3_standard == $past(avs_writedata[`CCR_PCFG_P3]))
                && (port_ctl.port2_standard == $past(avs_writedata[`CCR_PCFG_P2]))
                && (port_ctl.port0_standard == $past(avs_writedata[`CCR_PCFG_P0_DRV]))
                && (port_ctl.port0_push_pull == $past(avs_writedata[`CCR_PCFG_P0_PP]))
                && (port_ctl.cmp_to_port3 == $past(avs_writedata[`CCR_PCFG_CMP]));
    endproperty
    a_pcfg_write: assert property (p_pcfg_write)
        else $error("config write lost");
    // Writes to the stop recovery register never reach the stop flag
    property p_stop_ro;
        @(posedge clk_sys) disable iff (sys_rst)
            (wr_taken && !stop_recovery && bank_select == `CCR_BANK_F
                && avs_address == `CCR_IDX_STOP_REC)
            |=> (stop_rec_cfg[`CCR_STOP_FLAG] == $past(stop_rec_cfg[`CCR_STOP_FLAG]))
                && (stop_rec_cfg[6:0] == $past(avs_writedata[6:0]));
    endproperty
    a_stop_ro: assert property (p_stop_ro) else $error("stop flag written");
    // Plain byte registers take the written byte
    property p_gp_write;
        @(posedge clk_sys) disable iff (sys_rst)
            (wr_taken && avs_address == `CCR_IDX_GP_BYTE)
            |=> (st.general_purpose_byte == $past(avs_writedata[7:0]));
    endproperty
    a_gp_write: assert property (p_gp_write) else $error("byte write lost");
    property p_sp_write;
        @(posedge clk_sys) disable iff (sys_rst)
            (wr_taken && avs_address == `CCR_IDX_SP_LOW)
            |=> (stack_pointer_low_bits == $past(avs_writedata[7:0]));
    endproperty
    a_sp_write: assert property (p_sp_write) else $error("stack byte write lost");
    // Flag read data is the value before the taking edge
    property p_flag_read;
        @(posedge clk_sys) disable iff (sys_rst)
            (rd_taken && avs_address == `CCR_IDX_FLAGS)
            |=> (avs_readdata[7:0] == $past(status_flags));
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read wrong");
    // Write-only registers read back as zero
    property p_wo_read;
        @(posedge clk_sys) disable iff (sys_rst)
            (rd_taken && (avs_address == `CCR_IDX_PORT_CFG || avs_address == `CCR_IDX_STOP_REC2
                || avs_address == `CCR_IDX_WDOG_MODE))
            |=> (avs_readdata == 32'h00000000);
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only register read");
    // The stop flag is the only readable bank F bit
    property p_stop_read;
        @(posedge clk_sys) disable iff (sys_rst)
            (rd_taken && bank_select == `CCR_BANK_F && avs_address == `CCR_IDX_STOP_REC)
            |=> (avs_readdata[`CCR_STOP_FLAG] == $past(stop_rec_cfg[`CCR_STOP_FLAG]))
                && (avs_readdata[6:0] == 7'h00);
    endproperty
    a_stop_read: assert property (p_stop_read) else $error("stop flag read wrong");
    // Off bank F the stop recovery place reads zero
    property p_hidden_read;
        @(posedge clk_sys) disable iff (sys_rst)
            (rd_taken && bank_select != `CCR_BANK_F && avs_address == `CCR_IDX_STOP_REC)
            |=> (avs_readdata == 32'h00000000);
    endproperty
    a_hidden_read: assert property (p_hidden_read) else $error("hidden place read");

    // Main scenarios
    c_stop: cover property (@(posedge clk_sys) disable iff (sys_rst) stop_recovery);
    c_bankf: cover property (@(posedge clk_sys) disable iff (sys_rst)
        avs_write && bank_select == `CCR_BANK_F);
    c_flagw: cover property (@(posedge clk_sys) disable iff (sys_rst) flag_wr && core_flag_upd);
    c_cmp: cover property (@(posedge clk_sys) disable iff (sys_rst)
        port_ctl.cmp_to_port3 && cmp_result != 2'b00);
    c_stop_read: cover property (@(posedge clk_sys) disable iff (sys_rst)
        rd_taken && bank_select == `CCR_BANK_F && avs_address == `CCR_IDX_STOP_REC);
endmodule // ccr_ctrl_regs

// File: test/ccr_core_model.sv
// Purpose: Processor core model driving the register bus, flag updates and stop recovery
// Assumes: Each task is entered right after a rising edge of clk_sys
// Notes: Released bus lines carry inverted values so stale data never matches
`timescale 1ns/10ps
module ccr_core_model
(
    input wire logic clk_sys,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic core_flag_upd,
    output logic [5:0] core_flags,
    output logic stop_recovery
);
    initial
    begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        core_flag_upd = 1'b0;
        core_flags = 6'h00;
        stop_recovery = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One bus cycle; a core flag update may share the taking edge
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] dat,
                        input logic cu, input logic [5:0] cf, output logic [7:0] q);
        avs_address <= adr;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, dat};
        core_flag_upd <= cu;
        core_flags <= cf;
        @(posedge clk_sys);
        core_flag_upd <= 1'b0;
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~adr;
        avs_writedata <= ~{24'h000000, dat};
        core_flags <= ~cf;
        @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Flag update after an operation
    task automatic core_pulse(input logic [5:0] cf);
        core_flag_upd <= 1'b1;
        core_flags <= cf;
        @(posedge clk_sys);
        core_flag_upd <= 1'b0;
        core_flags <= ~cf;
        @(posedge clk_sys);
    endtask
    task automatic stop_pulse;
        stop_recovery <= 1'b1;
        @(posedge clk_sys);
        stop_recovery <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule // ccr_core_model

// File: test/test_cpu_control_and_port_config_regs.sv
// Purpose: Self-checking bench of the control and port configuration register bank
// Assumes: Bus answers one cycle after the taking edge
// Notes: Flags are never reset, so only the user flags are checked across a reset
`timescale 1ns/10ps
module test_cpu_control_and_port_config_regs;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, core_flag_upd;
    logic stop_recovery, port3_pin4, port3_pin7;
    logic [7:0] avs_address, port3_data, status_flags, sp_low, q;
    logic [7:0] stop_rec_cfg, stop_rec_cfg_two, watchdog_cfg;
    logic [31:0] avs_writedata, avs_readdata;
    logic [5:0] core_flags, port_ctl;
    logic [3:0] working_group, bank_select;
    logic [1:0] cmp_result;
    int errors = 0;
    int checks_done = 0;
    logic [23:0] rows [7] = '{24'hFDA5A5, 24'hFE3C3C, 24'hFF8181, 24'hFC5A5A, 24'hF07700,
                              24'h000000, 24'h0BFF00};
    logic [7:0] pbit [6] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h01};
    ccr_ctrl_regs i_ccr_ctrl_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_flag_upd(core_flag_upd),
        .core_flags(core_flags), .stop_recovery(stop_recovery), .port3_data(port3_data),
        .cmp_result(cmp_result), .status_flags(status_flags), .working_group(working_group),
        .bank_select(bank_select), .stack_pointer_low_bits(sp_low), .port_ctl(port_ctl),
        .stop_rec_cfg(stop_rec_cfg), .stop_rec_cfg_two(stop_rec_cfg_two),
        .watchdog_cfg(watchdog_cfg), .port3_pin4(port3_pin4), .port3_pin7(port3_pin7));
    ccr_core_model i_ccr_core_model (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .core_flag_upd(core_flag_upd),
        .core_flags(core_flags), .stop_recovery(stop_recovery));
    ////////////////////////////////////////////////////////////////////////////////
    always #10 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_ccr_core_model.xfer(1'b1, a, d, 1'b0, 6'h00, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_ccr_core_model.xfer(1'b0, a, 8'h00, 1'b0, 6'h00, q);
        chk(q, exp);
    endtask
    task automatic reset_pulse;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
    endtask
    task final_report;
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(20 * 5000);
        errors++;
        final_report();
    end
    initial
    begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        port3_data = 8'h00;
        cmp_result = 2'b00;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        // Reset values
        rd(8'hFD, 8'h00);
        rd(8'hFE, 8'h00);
        rd(8'hFF, 8'h00);
        chk({2'b00, port_ctl}, 8'h3E);
        chk(stop_rec_cfg, 8'h20);
        chk(stop_rec_cfg_two, 8'h00);
        chk(watchdog_cfg, 8'h0D);
        // Write then read back, bank 5 selected so bank F places stay hidden
        for (int i = 0; i < 7; i++)
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk({working_group, bank_select}, 8'hA5);
        chk(sp_low, 8'h81);
        chk({2'b00, port_ctl}, 8'h3E);
        chk(stop_rec_cfg, 8'h20);
        // Port configuration bits one at a time in bank F
        wr(8'hFD, 8'h0F);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h00, 8'h12 | pbit[i]);
            chk({2'b00, port_ctl}, 8'h01 << (5 - i));
        end
        rd(8'h00, 8'h00);
        port3_data <= 8'h10;
        cmp_result <= 2'b10;
        repeat (3) @(posedge clk_sys);
        chk({6'h00, port3_pin7, port3_pin4}, 8'h02);
        wr(8'h00, 8'h12);
        repeat (2) @(posedge clk_sys);
        chk({6'h00, port3_pin7, port3_pin4}, 8'h01);
        // Stop recovery keeps bank F contents and sets only the stop flag
        wr(8'h0B, 8'hFF);
        wr(8'h0D, 8'h03);
        wr(8'h0F, 8'h1E);
        chk(stop_rec_cfg, 8'h7F);
        rd(8'h0B, 8'h00);
        i_ccr_core_model.stop_pulse();
        chk(stop_rec_cfg, 8'hFF);
        rd(8'h0B, 8'h80);
        chk(stop_rec_cfg_two, 8'h03);
        chk(watchdog_cfg, 8'h1E);
        chk({2'b00, port_ctl}, 8'h00);
        // Core flag update, then software write on the same edge
        i_ccr_core_model.core_pulse(6'b101001);
        chk(status_flags, 8'hA6);
        i_ccr_core_model.xfer(1'b1, 8'hFC, 8'h0F, 1'b1, 6'h3F, q);
        chk(status_flags, 8'h0F);
        rd(8'hFC, 8'h0F);
        // Full reset in mid-run
        reset_pulse();
        chk({6'h00, status_flags[1:0]}, 8'h03);
        chk(stop_rec_cfg, 8'h20);
        chk({2'b00, port_ctl}, 8'h3E);
        chk(stop_rec_cfg_two, 8'h00);
        chk(watchdog_cfg, 8'h0D);
        chk({working_group, bank_select}, 8'h00);
        final_report();
    end
endmodule // test_cpu_control_and_port_config_regs
